// ---- rtl/pwc_pkg.sv ----
// Shared constants, timing counts and state encodings for the parallel word channel
package pwc_pkg;

   // ****************************************
   // Widths and clock
   // ****************************************
   localparam int CLK_MHZ = 125;
   localparam int WORD_W  = 30;
   localparam int TMR_W   = 12;
   localparam int HLP_W   = 16;

   // Minimum interval in ns to whole clock cycles, rounded up, never below one
   function automatic logic [TMR_W-1:0] pwc_cycles(input int t_ns);
      int c;
      c = (t_ns * CLK_MHZ + 999) / 1000;
      if (c < 1) begin
         c = 1;
      end
      return c[TMR_W-1:0];
   endfunction

   // ****************************************
   // Intervals in ns, as printed
   // ****************************************
   localparam int T_IN_DLY_NS   = 16000;
   localparam int T_IN_ACK_NS   = 8800;
   localparam int T_IN_GAP_NS   = 10000;
   localparam int T_SETTLE_NS   = 4400;
   localparam int T_OUT_DLY_NS  = 16000;
   localparam int T_STROBE_NS   = 8800;
   localparam int T_HOLD_NS     = 4000;
   localparam int T_OUT_GAP_NS  = 10000;
   localparam int T_FN_GAP_NS   = 2000;

   // ****************************************
   // Intervals in cycles
   // ****************************************
   localparam logic [TMR_W-1:0] IN_DLY_CYC  = pwc_cycles(T_IN_DLY_NS);
   localparam logic [TMR_W-1:0] IN_ACK_CYC  = pwc_cycles(T_IN_ACK_NS);
   localparam logic [TMR_W-1:0] IN_GAP_CYC  = pwc_cycles(T_IN_GAP_NS);
   localparam logic [TMR_W-1:0] SETTLE_CYC  = pwc_cycles(T_SETTLE_NS);
   localparam logic [TMR_W-1:0] OUT_DLY_CYC = pwc_cycles(T_OUT_DLY_NS);
   localparam logic [TMR_W-1:0] STROBE_CYC  = pwc_cycles(T_STROBE_NS);
   localparam logic [TMR_W-1:0] HOLD_CYC    = pwc_cycles(T_HOLD_NS);
   localparam logic [TMR_W-1:0] OUT_GAP_CYC = pwc_cycles(T_OUT_GAP_NS);
   localparam logic [TMR_W-1:0] FN_GAP_CYC  = pwc_cycles(T_FN_GAP_NS);

   // ****************************************
   // State encodings
   // ****************************************
   typedef enum logic [1:0] {
      IN_IDLE = 2'b01,
      IN_ACK  = 2'b10
   } pwc_in_st_t;

   typedef enum logic [5:0] {
      O_IDLE   = 6'b000001,
      O_WAIT   = 6'b000010,
      O_SETTLE = 6'b000100,
      O_STROBE = 6'b001000,
      O_HOLD   = 6'b010000,
      O_GAP    = 6'b100000
   } pwc_out_st_t;

   typedef enum logic [4:0] {
      X_IDLE  = 5'b00001,
      X_ARM   = 5'b00010,
      X_DRIVE = 5'b00100,
      X_WAIT  = 5'b01000,
      X_DROP  = 5'b10000
   } pwc_xc_st_t;

endpackage

// ---- rtl/pwc_tmr_if.sv ----
// Start, length and expiry signals between the channel and one interval timer
`timescale 1ns/1ns
interface pwc_tmr_if;
   logic                       start;
   logic [pwc_pkg::TMR_W-1:0]  len;
   logic                       expired;

   modport ctl (output start, output len, input expired);
   modport tmr (input start, input len, output expired);
endinterface

// ---- rtl/pwc_timer.sv ----
// One-shot interval timer: expired rises exactly len cycles after a start pulse
`timescale 1ns/1ns
module pwc_timer (
   input  logic       sys_clk,
   input  logic       rstn,
   pwc_tmr_if.tmr     tp
);
   import pwc_pkg::*;

   logic [TMR_W-1:0] count;

   // Idle timer reads as expired so nothing waits on it after reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count      <= '0;
         tp.expired <= 1'b1;
      end else if (tp.start) begin
         count      <= tp.len;
         tp.expired <= 1'b0;
      end else if (count != '0) begin
         count      <= count - 1'b1;
         tp.expired <= (count == {{(TMR_W-1){1'b0}}, 1'b1});
      end
   end

endmodule

// ---- rtl/pwc_chan.sv ----
// Handshake logic of one parallel word channel: input, output, command and link
`timescale 1ns/1ns
module pwc_chan (
   input  logic                        sys_clk,
   input  logic                        rstn,
   input  logic [pwc_pkg::WORD_W-1:0]  in_data,
   input  logic                        in_req,
   input  logic                        in_attn,
   output logic                        in_ack,
   output logic                        in_buf_active,
   input  logic                        in_enable,
   output logic [pwc_pkg::WORD_W-1:0]  rx_word,
   output logic                        rx_valid,
   output logic                        rx_attn,
   input  logic                        out_req,
   output logic [pwc_pkg::WORD_W-1:0]  out_data,
   output logic                        out_ack,
   output logic                        out_func,
   input  logic                        tx_valid,
   input  logic [pwc_pkg::WORD_W-1:0]  tx_data,
   input  logic                        tx_func,
   output logic                        tx_ready,
   input  logic                        xc_armed,
   input  logic                        xc_resume,
   output logic [pwc_pkg::WORD_W-1:0]  xc_data,
   output logic                        xc_ready,
   input  logic                        xw_valid,
   input  logic [pwc_pkg::WORD_W-1:0]  xw_data,
   output logic                        xw_ready
);
   import pwc_pkg::*;

   function automatic logic [HLP_W-1:0] sat_inc(input logic [HLP_W-1:0] v);
      return (v == {HLP_W{1'b1}}) ? v : v + 1'b1;
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [4:0]        sync_m;
   logic [4:0]        sync_s;
   logic [WORD_W-1:0] in_data_m;
   logic [WORD_W-1:0] in_data_s;
   logic              in_req_s;
   logic              in_attn_s;
   logic              out_req_s;
   logic              xc_resume_s;
   logic              xc_armed_s;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sync_m    <= '0;
         sync_s    <= '0;
         in_data_m <= '0;
         in_data_s <= '0;
      end else begin
         sync_m    <= {in_req, in_attn, out_req, xc_resume, xc_armed};
         sync_s    <= sync_m;
         in_data_m <= in_data;
         in_data_s <= in_data_m;
      end
   end

   assign {in_req_s, in_attn_s, out_req_s, xc_resume_s, xc_armed_s} = sync_s;

   // ****************************************
   // Interval timers
   // ****************************************
   pwc_tmr_if in_gap_if ();
   pwc_tmr_if in_age_if ();
   pwc_tmr_if in_pw_if ();
   pwc_tmr_if o_gap_if ();
   pwc_tmr_if o_age_if ();
   pwc_tmr_if o_step_if ();

   pwc_timer u_in_gap (.sys_clk(sys_clk), .rstn(rstn), .tp(in_gap_if));
   pwc_timer u_in_age (.sys_clk(sys_clk), .rstn(rstn), .tp(in_age_if));
   pwc_timer u_in_pw (.sys_clk(sys_clk), .rstn(rstn), .tp(in_pw_if));
   pwc_timer u_o_gap (.sys_clk(sys_clk), .rstn(rstn), .tp(o_gap_if));
   pwc_timer u_o_age (.sys_clk(sys_clk), .rstn(rstn), .tp(o_age_if));
   pwc_timer u_o_step (.sys_clk(sys_clk), .rstn(rstn), .tp(o_step_if));

   // ****************************************
   // Input channel
   // ****************************************
   pwc_in_st_t in_st;
   logic       in_any_d;
   logic       in_pend;
   logic       in_any;
   logic       in_rise;
   logic       in_fall;
   logic       in_rise_ok;
   logic       in_serve;

   // Attention shares the acknowledge, so it is qualified like a data request
   assign in_any     = in_req_s | in_attn_s;
   assign in_rise    = in_any & ~in_any_d;
   assign in_fall    = ~in_any & in_any_d;
   assign in_rise_ok = in_rise & in_gap_if.expired;
   assign in_serve   = (in_st == IN_IDLE) & in_pend & in_age_if.expired & in_enable;

   assign in_gap_if.start = in_fall;
   assign in_gap_if.len   = IN_GAP_CYC;
   assign in_age_if.start = in_rise_ok;
   assign in_age_if.len   = IN_DLY_CYC;
   assign in_pw_if.start  = in_serve;
   assign in_pw_if.len    = IN_ACK_CYC;

   // A rise seen while acknowledge is still high stays pending; set wins over serve
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         in_any_d <= 1'b0;
         in_pend  <= 1'b0;
      end else begin
         in_any_d <= in_any;
         if (in_rise_ok) begin
            in_pend <= 1'b1;
         end else if (in_serve) begin
            in_pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         in_st    <= IN_IDLE;
         in_ack   <= 1'b0;
         rx_word  <= '0;
         rx_valid <= 1'b0;
         rx_attn  <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         case (in_st)
            IN_IDLE: begin
               if (in_serve) begin
                  rx_word  <= in_data_s;
                  rx_attn  <= in_attn_s;
                  rx_valid <= 1'b1;
                  in_ack   <= 1'b1;
                  in_st    <= IN_ACK;
               end
            end
            IN_ACK: begin
               if (in_pw_if.expired) begin
                  in_ack <= 1'b0;
                  in_st  <= IN_IDLE;
               end
            end
            default: in_st <= IN_IDLE;
         endcase
      end
   end

   // Armed level seen by a sending computer on the link into this input
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         in_buf_active <= 1'b0;
      end else begin
         in_buf_active <= in_enable;
      end
   end

   // ****************************************
   // Output and command channel
   // ****************************************
   pwc_out_st_t       o_st;
   logic [WORD_W-1:0] o_stage;
   logic              o_is_fn;
   logic              o_req_d;
   logic              o_pend;
   logic              o_rise_ok;
   logic              o_serve;
   logic              o_take_fn;
   logic              o_load;

   assign o_rise_ok = out_req_s & ~o_req_d & o_gap_if.expired;
   assign o_serve   = (o_st == O_WAIT) & o_pend & o_age_if.expired;
   assign o_take_fn = (o_st == O_IDLE) & tx_valid & tx_ready & tx_func;
   assign o_load    = o_take_fn | o_serve;

   assign o_gap_if.start = ~out_req_s & o_req_d;
   assign o_gap_if.len   = OUT_GAP_CYC;
   assign o_age_if.start = o_rise_ok;
   assign o_age_if.len   = OUT_DLY_CYC;

   always_comb begin
      o_step_if.start = 1'b0;
      o_step_if.len   = SETTLE_CYC;
      case (o_st)
         O_IDLE:   o_step_if.start = o_take_fn;
         O_WAIT:   o_step_if.start = o_serve;
         O_SETTLE: begin
            o_step_if.start = o_step_if.expired;
            o_step_if.len   = STROBE_CYC;
         end
         O_STROBE: begin
            o_step_if.start = o_step_if.expired;
            o_step_if.len   = HOLD_CYC;
         end
         O_HOLD: begin
            o_step_if.start = o_step_if.expired & o_is_fn;
            o_step_if.len   = FN_GAP_CYC;
         end
         default: o_step_if.start = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         o_req_d <= 1'b0;
         o_pend  <= 1'b0;
      end else begin
         o_req_d <= out_req_s;
         if (o_rise_ok) begin
            o_pend <= 1'b1;
         end else if (o_serve) begin
            o_pend <= 1'b0;
         end
      end
   end

   // Data words wait for a request; command words go out unasked
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         o_st     <= O_IDLE;
         o_stage  <= '0;
         o_is_fn  <= 1'b0;
         out_data <= '0;
         out_ack  <= 1'b0;
         out_func <= 1'b0;
         tx_ready <= 1'b1;
      end else begin
         if (o_load) begin
            out_data <= o_take_fn ? tx_data : o_stage;
         end
         case (o_st)
            O_IDLE: begin
               if (tx_valid && tx_ready) begin
                  tx_ready <= 1'b0;
                  o_is_fn  <= tx_func;
                  o_stage  <= tx_data;
                  o_st     <= tx_func ? O_SETTLE : O_WAIT;
               end
            end
            O_WAIT: begin
               if (o_serve) begin
                  o_st <= O_SETTLE;
               end
            end
            O_SETTLE: begin
               if (o_step_if.expired) begin
                  out_ack  <= ~o_is_fn;
                  out_func <= o_is_fn;
                  o_st     <= O_STROBE;
               end
            end
            O_STROBE: begin
               if (o_step_if.expired) begin
                  out_ack  <= 1'b0;
                  out_func <= 1'b0;
                  o_st     <= O_HOLD;
               end
            end
            O_HOLD: begin
               if (o_step_if.expired) begin
                  o_st     <= o_is_fn ? O_GAP : O_IDLE;
                  tx_ready <= ~o_is_fn;
               end
            end
            O_GAP: begin
               if (o_step_if.expired) begin
                  o_st     <= O_IDLE;
                  tx_ready <= 1'b1;
               end
            end
            default: o_st <= O_IDLE;
         endcase
      end
   end

   // ****************************************
   // Computer-to-computer sending link
   // ****************************************
   pwc_xc_st_t        xc_st;
   logic [WORD_W-1:0] xc_word;

   // Waiting for resume to fall stops one long strobe ending two words
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         xc_st    <= X_IDLE;
         xc_word  <= '0;
         xc_data  <= '0;
         xc_ready <= 1'b0;
         xw_ready <= 1'b1;
      end else begin
         case (xc_st)
            X_IDLE: begin
               if (xw_valid) begin
                  xc_word  <= xw_data;
                  xw_ready <= 1'b0;
                  xc_st    <= X_ARM;
               end
            end
            X_ARM: begin
               if (xc_armed_s) begin
                  xc_data <= xc_word;
                  xc_st   <= X_DRIVE;
               end
            end
            X_DRIVE: begin
               xc_ready <= 1'b1;
               xc_st    <= X_WAIT;
            end
            X_WAIT: begin
               if (xc_resume_s) begin
                  xc_ready <= 1'b0;
                  xc_data  <= '0;
                  xc_st    <= X_DROP;
               end
            end
            X_DROP: begin
               if (!xc_resume_s) begin
                  xw_ready <= 1'b1;
                  xc_st    <= X_IDLE;
               end
            end
            default: xc_st <= X_IDLE;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   logic [HLP_W-1:0] in_since_rise;
   logic [HLP_W-1:0] ack_hi;
   logic [HLP_W-1:0] o_since_rise;
   logic [HLP_W-1:0] od_age;
   logic [HLP_W-1:0] strobe_low;
   logic [HLP_W-1:0] fn_hi;
   logic [HLP_W-1:0] fn_low;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         in_since_rise <= '1;
         ack_hi        <= '0;
         o_since_rise  <= '1;
         od_age        <= '1;
         strobe_low    <= '1;
         fn_hi         <= '0;
         fn_low        <= '1;
      end else begin
         in_since_rise <= in_rise_ok ? '0 : sat_inc(in_since_rise);
         ack_hi        <= in_ack ? sat_inc(ack_hi) : '0;
         o_since_rise  <= o_rise_ok ? '0 : sat_inc(o_since_rise);
         od_age        <= o_load ? '0 : sat_inc(od_age);
         strobe_low    <= (out_ack | out_func) ? '0 : sat_inc(strobe_low);
         fn_hi         <= out_func ? sat_inc(fn_hi) : '0;
         fn_low        <= out_func ? '0 : sat_inc(fn_low);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   in_ack_delay_a: assert property ($rose(in_ack) |-> in_since_rise >= IN_DLY_CYC)
      else $error("input acknowledge too soon after request");
   in_ack_second_a: assert property (in_rise_ok |-> ##1 (!$rose(in_ack)) [*8])
      else $error("acknowledge raised right after a new request");
   in_ack_width_a: assert property ($fell(in_ack) |-> ack_hi >= IN_ACK_CYC)
      else $error("input acknowledge too short");
   in_gap_a: assert property (in_rise && !in_gap_if.expired && !in_pend |=> !in_pend)
      else $error("request accepted without low gap");
   out_req_delay_a: assert property (o_serve |-> o_since_rise >= OUT_DLY_CYC)
      else $error("output word placed too soon after request");
   out_settle_a: assert property ($rose(out_ack) || $rose(out_func) |-> od_age >= SETTLE_CYC)
      else $error("strobe raised before data settled");
   out_hold_a: assert property ($changed(out_data) |-> strobe_low >= HOLD_CYC)
      else $error("output data changed during hold");
   fn_width_a: assert property ($fell(out_func) |-> fn_hi >= STROBE_CYC)
      else $error("command strobe too short");
   fn_gap_a: assert property ($rose(out_func) |-> fn_low >= FN_GAP_CYC)
      else $error("command strobe low gap too short");
   xc_order_a: assert property ($rose(xc_ready) |-> $stable(xc_data) && xc_st == X_WAIT)
      else $error("link word-valid raised with data moving");
   xc_drop_a: assert property (xc_ready && xc_resume_s |=> !xc_ready && xc_data == '0)
      else $error("link data not removed on resume");

   in_word_c: cover property ($rose(in_ack) ##1 rx_word != '0);
   // Back-to-back commands: the low time is counted in fn_low, not in a long delay range
   fn_pair_c: cover property ($rose(out_func) && fn_low < 16'h05dc);
   out_word_c: cover property ($rose(out_ack));
   xc_word_c: cover property ($fell(xc_ready) ##[1:20] xw_ready);

endmodule

// ---- test/pwc_periph.sv ----
// Far-side model: output peripheral and link receiving computer
`timescale 1ns/1ns
module pwc_periph (
   input  logic                       sys_clk,
   input  logic                       rstn,
   input  logic                       out_ack,
   input  logic [pwc_pkg::WORD_W-1:0] out_data,
   output logic                       out_req,
   input  logic                       xc_ready,
   input  logic [pwc_pkg::WORD_W-1:0] xc_data,
   output logic                       xc_armed,
   output logic                       xc_resume,
   input  logic                       arm_en,
   input  logic [7:0]                 slow,
   output logic [pwc_pkg::WORD_W-1:0] got_out,
   output logic                       got_out_v,
   output logic [pwc_pkg::WORD_W-1:0] got_xc,
   output logic                       got_xc_v
);
   import pwc_pkg::*;
   int gap;
   int dly;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         out_req   <= 1'b0;
         got_out   <= '0;
         got_out_v <= 1'b0;
         gap       <= 0;
      end else begin
         got_out_v <= 1'b0;
         if (out_req && out_ack) begin
            out_req   <= 1'b0;
            got_out   <= out_data;
            got_out_v <= 1'b1;
            gap       <= 1300;
         end else if (gap > 0) begin
            gap <= gap - 1;
         end else begin
            out_req <= 1'b1;
         end
      end
   end
   // Slow answers hold word-valid up for a random number of cycles
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         xc_armed  <= 1'b0;
         xc_resume <= 1'b0;
         got_xc    <= '0;
         got_xc_v  <= 1'b0;
         dly       <= 0;
      end else begin
         xc_armed <= arm_en;
         got_xc_v <= 1'b0;
         if (!xc_ready) begin
            xc_resume <= 1'b0;
            dly       <= 0;
         end else if (!xc_resume) begin
            dly <= dly + 1;
            if (dly >= int'(slow)) begin
               xc_resume <= 1'b1;
               got_xc    <= xc_data;
               got_xc_v  <= 1'b1;
            end
         end
      end
   end
endmodule

// ---- test/pwc_chan_bench.sv ----
// Self-checking bench for the parallel word channel
`timescale 1ns/1ns
module pwc_chan_bench;
   import pwc_pkg::*;
   logic              sys_clk = 0, rstn = 0, in_req = 0, in_attn = 0, in_enable = 1;
   logic              tx_valid = 0, tx_func = 0, xw_valid = 0, arm_en = 0;
   logic [WORD_W-1:0] in_data = '0, tx_data = '0, xw_data = '0, pd = '0;
   logic [WORD_W-1:0] rx_word, out_data, xc_data, got_out, got_xc;
   logic              in_ack, in_buf_active, rx_valid, rx_attn, out_req, out_ack, out_func;
   logic              tx_ready, xc_armed, xc_resume, xc_ready, xw_ready, got_out_v, got_xc_v;
   logic [7:0]        slow = '0;
   logic [3:0]        pv = '0;
   logic              pe = 1'b0;
   int                bad_count = 0, tests_run = 0, s_dat = 9999, s_req = 0;
   int                s_fall = 9999, s_fn = 9999, hi[3] = '{0, 0, 0};
   logic [WORD_W-1:0] oq[$], cq[$], xq[$];
   pwc_chan   pwc_chan_i (.*);
   pwc_periph pwc_periph_i (.*);
   initial forever #4 sys_clk = ~sys_clk;
   // ****
   // Checks
   // ****
   task automatic chk_w(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_min(input string nm, input int e, input int g);
      tests_run++;
      if (g < e) begin
         bad_count++;
         $display("[FAIL] %s expected >= %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic test_done();
      if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ****
   // Drivers
   // ****
   task automatic send_in(input logic at, input int gap);
      logic [WORD_W-1:0] w;
      int n;
      w = WORD_W'($urandom);
      repeat (gap) @(posedge sys_clk);
      in_data <= w;
      in_req <= !at;
      in_attn <= at;
      n = 0;
      do begin @(posedge sys_clk); n++; end while (in_ack !== 1'b1 && n < 9000);
      chk_w("in ack seen", WORD_W'(1), WORD_W'(in_ack));
      chk_min("in delay", IN_DLY_CYC, n);
      chk_w("rx word", w, rx_word);
      chk_w("rx attn", WORD_W'(at), WORD_W'(rx_attn));
      in_req <= 1'b0;
      in_attn <= 1'b0;
      in_data <= ~w;
   endtask
   // Kind 0 data word, 1 command word, 2 link word
   task automatic put(input int k);
      logic [WORD_W-1:0] w;
      int n;
      w = WORD_W'($urandom);
      @(posedge sys_clk);
      if (k == 2) begin
         xq.push_back(w);
         xw_valid <= 1'b1;
         xw_data <= w;
      end else begin
         if (k == 0) oq.push_back(w);
         else cq.push_back(w);
         tx_valid <= 1'b1;
         tx_data <= w;
         tx_func <= k[0];
      end
      n = 0;
      do begin @(posedge sys_clk); n++; end
      while ((k == 2 ? xw_ready : tx_ready) !== 1'b1 && n < 20000);
      xw_valid <= 1'b0;
      tx_valid <= 1'b0;
   endtask
   // ****
   // Pin monitor
   // ****
   always @(posedge sys_clk) begin
      if (rstn === 1'b1) begin
         s_dat++;
         s_req++;
         s_fall++;
         s_fn++;
         if (out_data !== pd) begin
            chk_min("data hold", HOLD_CYC, s_fall);
            s_dat = 0;
         end
         if (out_req && !pv[3]) s_req = 0;
         if (out_ack && !pv[1]) begin
            chk_min("ack settle", SETTLE_CYC, s_dat);
            chk_min("req to ack", OUT_DLY_CYC + SETTLE_CYC, s_req);
         end
         if (out_func && !pv[2]) begin
            chk_min("strobe settle", SETTLE_CYC, s_dat);
            chk_min("strobe gap", FN_GAP_CYC, s_fn);
            chk_w("code", cq.pop_front(), out_data);
         end
         if (in_ack && !pv[0]) chk_w("rx pulse", WORD_W'(1), WORD_W'(rx_valid));
         chk_w("ack with strobe", '0, WORD_W'(out_ack & out_func));
         chk_w("buf active", WORD_W'(pe), WORD_W'(in_buf_active));
         if (got_out_v) chk_w("out word", oq.pop_front(), got_out);
         if (got_xc_v) chk_w("link word", xq.pop_front(), got_xc);
         for (int i = 0; i < 3; i++) begin
            if (pv[i] && !(i == 0 ? in_ack : i == 1 ? out_ack : out_func)) begin
               chk_min("high width", i ? STROBE_CYC : IN_ACK_CYC, hi[i]);
               hi[i] = 0;
            end else if (pv[i]) hi[i]++;
         end
         if ((pv[1] && !out_ack) || (pv[2] && !out_func)) s_fall = 0;
         if (pv[2] && !out_func) s_fn = 0;
      end
      pd = out_data;
      pv = {out_req, out_func, out_ack, in_ack};
      pe = in_enable & rstn;
   end
   // ****
   // Main sequence
   // ****
   initial begin
      int n;
      void'($urandom(32'he565b097));
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      send_in(1'b0, 1);
      // Rise inside the gap must never be answered
      repeat (1150) @(posedge sys_clk);
      in_req <= 1'b1;
      n = 0;
      repeat (2600) begin @(posedge sys_clk); if (in_ack === 1'b1) n++; end
      chk_w("short gap ack", '0, WORD_W'(n));
      in_req <= 1'b0;
      in_enable <= 1'b0;
      // A request made while the buffer is disarmed must wait, unanswered
      fork
         send_in(1'b0, 1260);
         begin
            n = 0;
            repeat (4000) begin @(posedge sys_clk); if (in_ack === 1'b1) n++; end
            chk_w("ack while disarmed", '0, WORD_W'(n));
            in_enable <= 1'b1;
         end
      join
      for (int i = 0; i < 4; i++) send_in(1'($urandom), 1260);
      for (int i = 0; i < 3; i++) put(0);
      for (int i = 0; i < 3; i++) put(1);
      put(2);
      repeat (40) @(posedge sys_clk);
      chk_w("link unarmed", '0, xc_data | WORD_W'(xc_ready));
      arm_en <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         slow <= 8'($urandom);
         put(2);
      end
      for (int i = 0; i < 20000 && oq.size() + cq.size() + xq.size() > 0; i++)
         @(posedge sys_clk);
      chk_w("pending", '0, WORD_W'(oq.size() + cq.size() + xq.size()));
      test_done();
   end
   initial begin
      repeat (100000) @(posedge sys_clk);
      bad_count++;
      test_done();
   end
endmodule
